// ---- design/cmpc_consts.svh ----
`ifndef CMPC_CONSTS_SVH
`define CMPC_CONSTS_SVH
`define CMPC_OFF_CTRL_ONE 8'h00
`define CMPC_OFF_CTRL_TWO 8'h04
`define CMPC_OFF_MIRROR 8'h08
`define CMPC_OFF_IRQ_STAT 8'h0C
`define CMPC_OFF_IRQ_MASK 8'h10
`define CMPC_OFF_IRQ_CTRL 8'h14
`define CMPC_OFF_PORT_DATA 8'h18
`define CMPC_OFF_ANALOG_SEL 8'h1C
`define CMPC_C1_ON 7
`define CMPC_C1_OUT 6
`define CMPC_C1_OE 5
`define CMPC_C1_POL 4
`define CMPC_C1_SP 2
`define CMPC_C1_HYS 1
`define CMPC_C1_SYNC 0
`define CMPC_C2_INTP 7
`define CMPC_C2_INTN 6
`define CMPC_C2_PCH_HI 5
`define CMPC_C2_PCH_LO 4
`define CMPC_C2_NCH 0
`define CMPC_C2_MASK 8'hF1
`define CMPC_C1_WMASK 8'hB7
`define CMPC_RESET_BYTE 8'h00
`define CMPC_PORT_W 6
`define CMPC_RESP_OKAY 2'b00
`define CMPC_RESP_SLVERR 2'b10
`endif

// ---- design/cmpc_pkg.sv ----
package cmpc_pkg;
    typedef enum logic [1:0] {
        CMPC_PSEL_PIN,
        CMPC_PSEL_DAC,
        CMPC_PSEL_FVR,
        CMPC_PSEL_NONE
    } cmpc_psel_t;
endpackage

// ---- design/cmpc_sync2.sv ----
`timescale 1ns/100ps
`default_nettype none
module cmpc_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ---- design/cmpc_edge.sv ----
`timescale 1ns/100ps
`default_nettype none
module cmpc_edge (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic prev_reg;
    // Previous-cycle copy gives exactly one pulse per transition
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level;
        end
    end
    assign rise = level & ~prev_reg;
    assign fall = ~level & prev_reg;
endmodule
`default_nettype wire

// ---- design/cmpc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "cmpc_consts.svh"
module cmpc_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic analog_cmp_raw,
    input wire logic timer_src_clk,
    input wire logic [5:0] port_pins,
    input wire logic peripheral_irq_enable,
    input wire logic global_irq_enable,
    output logic [1:0] noninverting_node_sel,
    output logic noninverting_connect,
    output logic inverting_node_sel,
    output logic inverting_connect,
    output logic speed_power_select,
    output logic hysteresis_enable,
    output logic comparator_out_pin,
    output logic comparator_out_pin_oe_n,
    output logic pwm_shutdown_src,
    output logic cpu_irq,
    output logic irq
);
    logic [7:0] ctrl_one_reg;
    logic [7:0] ctrl_two_reg;
    logic irq_flag_reg;
    logic irq_mask_reg;
    logic irq_enable_reg;
    logic [5:0] analog_sel_reg;
    logic sync_latch_reg;
    logic tclk_prev_reg;
    logic cmp_s;
    logic tclk_s;
    logic [5:0] pins_s;
    logic cmp_pol;
    logic cmp_out;
    logic out_rise;
    logic out_fall;
    logic flag_set;
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_write;
    logic do_read;
    logic [31:0] rd_val;
    logic rd_ok;
    logic wr_ok;
    logic [1:0] psel;

    cmpc_sync2 #(.W(8)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({analog_cmp_raw, timer_src_clk, port_pins}),
        .q({cmp_s, tclk_s, pins_s})
    );

    // Polarity applies even when off, so toggling it can make an edge
    assign cmp_pol = (ctrl_one_reg[`CMPC_C1_ON] & cmp_s) ^ ctrl_one_reg[`CMPC_C1_POL];

    // Latch on falling timer source edge so the timer never counts mid-change
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tclk_prev_reg <= 1'b0;
            sync_latch_reg <= 1'b0;
        end else begin
            tclk_prev_reg <= tclk_s;
            if (tclk_prev_reg && !tclk_s) begin
                sync_latch_reg <= cmp_pol;
            end
        end
    end
    assign cmp_out = ctrl_one_reg[`CMPC_C1_SYNC] ? sync_latch_reg : cmp_pol;

    cmpc_edge u_edge (
        .clk(clk),
        .rst_n(rst_n),
        .level(cmp_out),
        .rise(out_rise),
        .fall(out_fall)
    );

    assign flag_set = (out_rise & ctrl_two_reg[`CMPC_C2_INTP])
                    | (out_fall & ctrl_two_reg[`CMPC_C2_INTN]);

    // AXI4-Lite write: address and data taken in either order
    assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CMPC_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `CMPC_RESP_OKAY : `CMPC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        if (awaddr_reg == `CMPC_OFF_CTRL_ONE) begin
            wr_ok = 1'b1;
        end else if (awaddr_reg == `CMPC_OFF_CTRL_TWO) begin
            wr_ok = 1'b1;
        end else if (awaddr_reg == `CMPC_OFF_MIRROR) begin
            wr_ok = 1'b1;
        end else if (awaddr_reg == `CMPC_OFF_IRQ_STAT) begin
            wr_ok = 1'b1;
        end else if (awaddr_reg == `CMPC_OFF_IRQ_MASK) begin
            wr_ok = 1'b1;
        end else if (awaddr_reg == `CMPC_OFF_IRQ_CTRL) begin
            wr_ok = 1'b1;
        end else if (awaddr_reg == `CMPC_OFF_PORT_DATA) begin
            wr_ok = 1'b1;
        end else if (awaddr_reg == `CMPC_OFF_ANALOG_SEL) begin
            wr_ok = 1'b1;
        end else begin
            wr_ok = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_one_reg <= `CMPC_RESET_BYTE;
            ctrl_two_reg <= `CMPC_RESET_BYTE;
            irq_mask_reg <= 1'b0;
            irq_enable_reg <= 1'b0;
            analog_sel_reg <= 6'h00;
        end else if (do_write && wstrb_reg[0]) begin
            if (awaddr_reg == `CMPC_OFF_CTRL_ONE) begin
                // Output bit is status only
                ctrl_one_reg <= (wdata_reg[7:0] & `CMPC_C1_WMASK);
            end else if (awaddr_reg == `CMPC_OFF_CTRL_TWO) begin
                ctrl_two_reg <= wdata_reg[7:0] & `CMPC_C2_MASK;
            end else if (awaddr_reg == `CMPC_OFF_IRQ_MASK) begin
                irq_mask_reg <= wdata_reg[0];
            end else if (awaddr_reg == `CMPC_OFF_IRQ_CTRL) begin
                irq_enable_reg <= wdata_reg[0];
            end else if (awaddr_reg == `CMPC_OFF_ANALOG_SEL) begin
                analog_sel_reg <= wdata_reg[5:0];
            end
        end
    end

    // AXI4-Lite read: one-cycle answer from registered data
    assign do_read = s_axi_arvalid & s_axi_arready;
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        if (s_axi_araddr == `CMPC_OFF_CTRL_ONE) begin
            rd_val[7:0] = {ctrl_one_reg[7], cmp_out, ctrl_one_reg[5:0]};
        end else if (s_axi_araddr == `CMPC_OFF_CTRL_TWO) begin
            rd_val[7:0] = ctrl_two_reg & `CMPC_C2_MASK;
        end else if (s_axi_araddr == `CMPC_OFF_MIRROR) begin
            rd_val[0] = cmp_out;
        end else if (s_axi_araddr == `CMPC_OFF_IRQ_STAT) begin
            rd_val[0] = irq_flag_reg;
        end else if (s_axi_araddr == `CMPC_OFF_IRQ_MASK) begin
            rd_val[0] = irq_mask_reg;
        end else if (s_axi_araddr == `CMPC_OFF_IRQ_CTRL) begin
            rd_val[0] = irq_enable_reg;
        end else if (s_axi_araddr == `CMPC_OFF_PORT_DATA) begin
            rd_val[5:0] = pins_s & ~analog_sel_reg;
        end else if (s_axi_araddr == `CMPC_OFF_ANALOG_SEL) begin
            rd_val[5:0] = analog_sel_reg;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CMPC_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_ok ? `CMPC_RESP_OKAY : `CMPC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Read of status clears the flag, but a new edge in that cycle wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_flag_reg <= 1'b0;
        end else if (flag_set) begin
            irq_flag_reg <= 1'b1;
        end else if (do_read && s_axi_araddr == `CMPC_OFF_IRQ_STAT) begin
            irq_flag_reg <= 1'b0;
        end
    end

    assign psel = ctrl_two_reg[`CMPC_C2_PCH_HI:`CMPC_C2_PCH_LO];
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            noninverting_node_sel <= cmpc_pkg::CMPC_PSEL_PIN;
            noninverting_connect <= 1'b0;
            inverting_node_sel <= 1'b0;
            inverting_connect <= 1'b0;
            speed_power_select <= 1'b0;
            hysteresis_enable <= 1'b0;
            comparator_out_pin <= 1'b0;
            comparator_out_pin_oe_n <= 1'b1;
            pwm_shutdown_src <= 1'b0;
            cpu_irq <= 1'b0;
            irq <= 1'b0;
        end else begin
            noninverting_node_sel <= psel;
            // Code 11 has no documented node, so it stays disconnected
            noninverting_connect <= ctrl_one_reg[`CMPC_C1_ON] &
                (psel != cmpc_pkg::CMPC_PSEL_NONE);
            inverting_node_sel <= ctrl_two_reg[`CMPC_C2_NCH];
            inverting_connect <= ctrl_one_reg[`CMPC_C1_ON];
            speed_power_select <= ctrl_one_reg[`CMPC_C1_SP];
            hysteresis_enable <= ctrl_one_reg[`CMPC_C1_HYS];
            comparator_out_pin <= cmp_out;
            comparator_out_pin_oe_n <= ~ctrl_one_reg[`CMPC_C1_OE];
            pwm_shutdown_src <= cmp_out;
            cpu_irq <= irq_flag_reg & irq_enable_reg & ctrl_one_reg[`CMPC_C1_ON] &
                peripheral_irq_enable & global_irq_enable;
            irq <= irq_flag_reg & irq_mask_reg;
        end
    end
endmodule
`default_nettype wire

// ---- test/cmpc_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module cmpc_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic peripheral_irq_enable,
    input wire logic global_irq_enable,
    input wire logic [1:0] noninverting_node_sel,
    input wire logic noninverting_connect,
    input wire logic inverting_node_sel,
    input wire logic inverting_connect,
    input wire logic cpu_irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    conn_needs_on_a: assert property (noninverting_connect |-> inverting_connect)
        else $error("positive input connected while comparator off");
    conn_sel_legal_a: assert property (noninverting_connect |-> noninverting_node_sel != 2'b11)
        else $error("positive input connected on unused selection");
    reset_clear_a: assert property ($rose(rst_n) |->
        noninverting_node_sel == 2'b00 && !inverting_node_sel && !inverting_connect)
        else $error("selections not cleared by reset");
    irq_gate_a: assert property (cpu_irq |->
        $past(peripheral_irq_enable) && $past(global_irq_enable))
        else $error("processor interrupt without global enables");
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    w_pulse_a: assert property (s_axi_wready |=> !s_axi_wready)
        else $error("wready longer than one cycle");
    ar_answer_a: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("rvalid not one cycle after arready");
    b_answer_a: assert property (s_axi_awready && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
endmodule
bind cmpc_top cmpc_asserts cmpc_asserts_i (.*);
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, noninverting_node_sel, rrsp;
    logic analog_cmp_raw, timer_src_clk, peripheral_irq_enable, global_irq_enable, nb;
    logic [5:0] port_pins, pv, av;
    logic noninverting_connect, inverting_node_sel, inverting_connect, speed_power_select;
    logic hysteresis_enable, comparator_out_pin, comparator_out_pin_oe_n, pwm_shutdown_src;
    logic cpu_irq, irq;
    int err_count, total_checks, cyc, seed;

    cmpc_top cmpc_top_i (.*);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task conclude;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Generous ceiling; the whole sequence needs well under two thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_count++;
            conclude();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rdat = s_axi_rdata;
        rrsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk("read", e, rdat);
    endtask

    // Covers the two-stage input sync, output register and edge detector
    task settle;
        repeat (8) @(posedge clk);
        #1;
    endtask

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        {analog_cmp_raw, timer_src_clk, peripheral_irq_enable, global_irq_enable} = '0;
        port_pins = 6'h00;
        rst_n = 1'b0;
        seed = 35;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        peripheral_irq_enable <= 1'b1;
        global_irq_enable <= 1'b1;
        rdc(8'h04, 32'h0000_0000);
        rdc(8'h08, 32'h0000_0000);
        wr(8'h04, 32'h0000_00FF);
        rdc(8'h04, 32'h0000_00F1);
        rd(8'h20);
        chk("unmapped_resp", 32'h0000_0002, {30'h0, rrsp});
        chk("unmapped_data", 32'h0000_0000, rdat);
        for (int on = 0; on < 2; on++) begin
            for (int p = 0; p < 3; p++) begin
                nb = $random(seed);
                wr(8'h00, {24'h0, on[0], 7'h0});
                wr(8'h04, {26'h0, p[1:0], 3'h0, nb});
                settle();
                chk("psel", p, {30'h0, noninverting_node_sel});
                chk("nsel", {31'h0, nb}, {31'h0, inverting_node_sel});
                chk("pconn", on, {31'h0, noninverting_connect});
                chk("nconn", on, {31'h0, inverting_connect});
            end
        end
        wr(8'h10, 32'h0000_0001);
        wr(8'h14, 32'h0000_0001);
        wr(8'h00, 32'h0000_00A0);
        for (int k = 0; k < 4; k++) begin
            wr(8'h04, {24'h0, k[1:0], 6'h0});
            rd(8'h0C);
            analog_cmp_raw <= 1'b1;
            settle();
            chk("irq", {31'h0, k[1]}, {31'h0, irq});
            chk("cpu_irq", {31'h0, k[1]}, {31'h0, cpu_irq});
            chk("pin", 32'h0000_0001, {31'h0, comparator_out_pin});
            chk("oe_n", 32'h0000_0000, {31'h0, comparator_out_pin_oe_n});
            chk("shutdown", 32'h0000_0001, {31'h0, pwm_shutdown_src});
            rdc(8'h08, 32'h0000_0001);
            rdc(8'h0C, {31'h0, k[1]});
            analog_cmp_raw <= 1'b0;
            settle();
            rdc(8'h0C, {31'h0, k[0]});
        end
        wr(8'h04, 32'h0000_0080);
        rd(8'h0C);
        wr(8'h00, 32'h0000_0010);
        settle();
        rdc(8'h0C, 32'h0000_0001);
        rdc(8'h0C, 32'h0000_0000);
        wr(8'h10, 32'h0000_0000);
        wr(8'h04, 32'h0000_00C0);
        wr(8'h00, 32'h0000_0000);
        settle();
        chk("irq_masked", 32'h0000_0000, {31'h0, irq});
        rdc(8'h0C, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            pv = $random(seed);
            av = $random(seed);
            port_pins <= pv;
            wr(8'h1C, {26'h0, av});
            settle();
            rdc(8'h18, {26'h0, pv & ~av});
        end
        wr(8'h00, 32'h0000_0006);
        settle();
        chk("speed_power", 32'h0000_0001, {31'h0, speed_power_select});
        chk("hysteresis", 32'h0000_0001, {31'h0, hysteresis_enable});
        rdc(8'h00, 32'h0000_0006);
        // Sync on: output holds until the timer source clock falls
        wr(8'h00, 32'h0000_0081);
        analog_cmp_raw <= 1'b1;
        settle();
        rdc(8'h08, 32'h0000_0000);
        timer_src_clk <= 1'b1;
        settle();
        rdc(8'h08, 32'h0000_0000);
        timer_src_clk <= 1'b0;
        settle();
        rdc(8'h08, 32'h0000_0001);
        rdc(8'h00, 32'h0000_00C1);
        conclude();
    end
endmodule
`default_nettype wire
